// ==== core/serdes_test_clock_reset_ctrl.sv ====
// per-channel test pattern, lane clock select and self-clearing reset registers
// assumes a management register port already decoded from the serial frames,
// running on the management clock; one access per cycle at most
// How it works
// - generate bit enables fast side pattern transmit
// - verify bit enables fast side pattern checking
// - choice codes 000-100 pick frequency/compliant patterns
// - codes 101-111 pick prbs, reset 101
// - verify errors accumulate in readable error tally
// - slow prbs choice 00/10/11, 01 reserved
// - loopback bit selects deep remote loopback
// - per lane transmit buffer clear, self clearing
// - lane three clock from lane0, lane2, own
// - lane two clock from lane0 or own
// - lane one clock from lane0 or own
// - per lane receive buffer clear bits
// - bits 6 and 5 clear fast receive buffers
// - writing one restarts link training
// - datapath clear keeps management registers intact
// - self clearing bits drop next cycle
// - error tally clears when read
`timescale 1ns/100ps
module serdes_test_clock_reset_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // management register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWriteData,
    output logic [15:0] regReadData,
    output logic regReadValid,
    // fast side pattern engine
    output logic fastSidePatternGenerate,
    output logic fastSidePatternVerify,
    output serdes_test_clock_reset_pkg::fast_pattern_t fastSidePatternChoice,
    input wire logic fastSidePatternError,
    // slow lane test and loopback
    output serdes_test_clock_reset_pkg::slow_prbs_t slowLanePrbsChoice,
    output logic farEndDeepLoopback,
    // lane transmit byte clock sources
    output serdes_test_clock_reset_pkg::clock_source_t laneThreeClockSource,
    output serdes_test_clock_reset_pkg::clock_source_t laneTwoClockSource,
    output serdes_test_clock_reset_pkg::clock_source_t laneOneClockSource,
    // one-cycle reset pulses
    output logic [3:0] slowLaneTxBufferClear,
    output logic [3:0] slowLaneRxBufferClear,
    output logic fastRxSecondBufferClear,
    output logic fastRxFirstBufferClear,
    output logic linkTrainingRerun,
    output logic datapathClear
);

    logic [15:0] patternControl_ff;
    logic [15:0] laneClock_ff;
    logic [15:0] triggers_ff;
    logic [15:0] errorTally_ff;
    logic [15:0] nxt_readData;
    logic writePattern;
    logic writeLaneClock;
    logic writeTrigger;
    logic readTally;

    // address match shared by write and read decode
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
        hit = (addr == target);
    endfunction

    assign writePattern = regWrite && hit(regAddr, serdes_test_clock_reset_pkg::PATTERN_CONTROL_ADDR);
    assign writeLaneClock = regWrite && hit(regAddr, serdes_test_clock_reset_pkg::LANE_CLOCK_ADDR);
    assign writeTrigger = regWrite && hit(regAddr, serdes_test_clock_reset_pkg::RESET_TRIGGER_ADDR);
    assign readTally = regRead && hit(regAddr, serdes_test_clock_reset_pkg::ERROR_TALLY_ADDR);

    // pattern control; reserved bits masked so they always read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            patternControl_ff <= serdes_test_clock_reset_pkg::PATTERN_CONTROL_RESET;
        end else if (writePattern) begin
            patternControl_ff <= regWriteData & serdes_test_clock_reset_pkg::PATTERN_CONTROL_MASK;
        end
    end

    // lane clock select; the buffer clear field lives in triggers_ff
    always_ff @(posedge clock) begin
        if (rst) begin
            laneClock_ff <= serdes_test_clock_reset_pkg::LANE_CLOCK_RESET;
        end else if (writeLaneClock) begin
            laneClock_ff <= regWriteData & serdes_test_clock_reset_pkg::LANE_CLOCK_MASK;
        end
    end

    // self clearing triggers: transmit clears in [15:12], others in place
    // packing both registers' triggers here keeps one clearing path
    always_ff @(posedge clock) begin
        if (rst) begin
            triggers_ff <= serdes_test_clock_reset_pkg::RESET_TRIGGER_RESET;
        end else begin
            triggers_ff <= serdes_test_clock_reset_pkg::RESET_TRIGGER_RESET;
            if (writeTrigger) begin
                triggers_ff[11:0] <= regWriteData[11:0] & serdes_test_clock_reset_pkg::TRIGGER_MASK[11:0];
            end
            if (writeLaneClock) begin
                triggers_ff[15:12] <= regWriteData[serdes_test_clock_reset_pkg::TX_CLEAR_LSB +: 4];
            end
        end
    end

    // error tally: counts during verify, saturates, cleared by a read;
    // an error in the read cycle is kept so no event is lost
    always_ff @(posedge clock) begin
        if (rst) begin
            errorTally_ff <= serdes_test_clock_reset_pkg::ERROR_TALLY_RESET;
        end else if (readTally) begin
            errorTally_ff <= (fastSidePatternVerify && fastSidePatternError) ? 16'h0001
                : serdes_test_clock_reset_pkg::ERROR_TALLY_CLEAR;
        end else if (fastSidePatternVerify && fastSidePatternError &&
                     errorTally_ff != serdes_test_clock_reset_pkg::ERROR_TALLY_MAX) begin
            errorTally_ff <= errorTally_ff + 16'h0001;
        end
    end

    // read mux; unmapped indexes answer zero, triggers read as zero
    always_comb begin
        nxt_readData = 16'h0000;
        if (hit(regAddr, serdes_test_clock_reset_pkg::PATTERN_CONTROL_ADDR)) begin
            nxt_readData = patternControl_ff;
        end else if (hit(regAddr, serdes_test_clock_reset_pkg::LANE_CLOCK_ADDR)) begin
            nxt_readData = laneClock_ff;
        end else if (hit(regAddr, serdes_test_clock_reset_pkg::ERROR_TALLY_ADDR)) begin
            nxt_readData = errorTally_ff;
        end
    end

    // read data registered one cycle after the request
    always_ff @(posedge clock) begin
        if (rst) begin
            regReadData <= 16'h0000;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                regReadData <= nxt_readData;
            end
        end
    end

    // static controls straight from the register fields
    assign fastSidePatternGenerate = patternControl_ff[serdes_test_clock_reset_pkg::GENERATE_BIT];
    assign fastSidePatternVerify = patternControl_ff[serdes_test_clock_reset_pkg::VERIFY_BIT];
    assign fastSidePatternChoice = serdes_test_clock_reset_pkg::fast_pattern_t'(
        patternControl_ff[serdes_test_clock_reset_pkg::FAST_CHOICE_LSB +: 3]);
    assign slowLanePrbsChoice = serdes_test_clock_reset_pkg::slow_prbs_t'(
        patternControl_ff[serdes_test_clock_reset_pkg::SLOW_CHOICE_LSB +: 2]);
    assign farEndDeepLoopback = patternControl_ff[serdes_test_clock_reset_pkg::LOOPBACK_BIT];

    // lane three: 1x means own clock
    always_comb begin
        case (laneClock_ff[serdes_test_clock_reset_pkg::LANE_THREE_LSB +: 2])
            2'h0: laneThreeClockSource = serdes_test_clock_reset_pkg::SRC_LANE0;
            2'h1: laneThreeClockSource = serdes_test_clock_reset_pkg::SRC_LANE2;
            default: laneThreeClockSource = serdes_test_clock_reset_pkg::SRC_OWN;
        endcase
    end

    assign laneTwoClockSource = laneClock_ff[serdes_test_clock_reset_pkg::LANE_TWO_BIT]
        ? serdes_test_clock_reset_pkg::SRC_OWN : serdes_test_clock_reset_pkg::SRC_LANE0;
    assign laneOneClockSource = laneClock_ff[serdes_test_clock_reset_pkg::LANE_ONE_BIT]
        ? serdes_test_clock_reset_pkg::SRC_OWN : serdes_test_clock_reset_pkg::SRC_LANE0;

    // per lane buffer clear pulses
    genvar lane;
    generate
        for (lane = 0; lane < serdes_test_clock_reset_pkg::LANE_COUNT; lane++) begin : g_lane
            assign slowLaneTxBufferClear[lane] = triggers_ff[12 + lane];
            assign slowLaneRxBufferClear[lane] =
                triggers_ff[serdes_test_clock_reset_pkg::RX_CLEAR_LSB + lane];
        end
    endgenerate

    // pulses; datapath clear does not touch any register here
    assign fastRxSecondBufferClear = triggers_ff[serdes_test_clock_reset_pkg::FAST_RX_SECOND_BIT];
    assign fastRxFirstBufferClear = triggers_ff[serdes_test_clock_reset_pkg::FAST_RX_FIRST_BIT];
    assign linkTrainingRerun = triggers_ff[serdes_test_clock_reset_pkg::TRAINING_BIT];
    assign datapathClear = triggers_ff[serdes_test_clock_reset_pkg::DATAPATH_BIT];

endmodule

// ==== core/serdes_test_clock_reset_pkg.sv ====
// constants for the channel test, lane clock and reset trigger registers
// assumes a register port with a 5-bit register index and 16-bit data
package serdes_test_clock_reset_pkg;
    localparam logic [4:0] PATTERN_CONTROL_ADDR = 5'h0b;
    localparam logic [4:0] LANE_CLOCK_ADDR = 5'h0d;
    localparam logic [4:0] RESET_TRIGGER_ADDR = 5'h0e;
    localparam logic [4:0] ERROR_TALLY_ADDR = 5'h10;
    localparam logic [15:0] PATTERN_CONTROL_RESET = 16'h0520;
    localparam logic [15:0] LANE_CLOCK_RESET = 16'h0000;
    localparam logic [15:0] RESET_TRIGGER_RESET = 16'h0000;
    localparam logic [15:0] ERROR_TALLY_RESET = 16'hfffd;
    localparam logic [15:0] ERROR_TALLY_CLEAR = 16'h0000;
    localparam logic [15:0] ERROR_TALLY_MAX = 16'hffff;
    // pattern control fields
    localparam int GENERATE_BIT = 13;
    localparam int VERIFY_BIT = 12;
    localparam int FAST_CHOICE_LSB = 8;
    localparam int SLOW_CHOICE_LSB = 4;
    localparam int LOOPBACK_BIT = 3;
    localparam logic [15:0] PATTERN_CONTROL_MASK = 16'h3738;
    // lane clock fields
    localparam int TX_CLEAR_LSB = 8;
    localparam int LANE_THREE_LSB = 2;
    localparam int LANE_TWO_BIT = 1;
    localparam int LANE_ONE_BIT = 0;
    localparam logic [15:0] LANE_CLOCK_MASK = 16'h000f;
    // reset trigger fields
    localparam int RX_CLEAR_LSB = 8;
    localparam int FAST_RX_SECOND_BIT = 6;
    localparam int FAST_RX_FIRST_BIT = 5;
    localparam int TRAINING_BIT = 4;
    localparam int DATAPATH_BIT = 3;
    localparam logic [15:0] TRIGGER_MASK = 16'h0f78;
    localparam int LANE_COUNT = 4;
    // fast side pattern choices
    typedef enum logic [2:0] {
        PAT_HIGH_FREQ, PAT_LOW_FREQ, PAT_MIXED_FREQ, PAT_COMPLIANT_RANDOM_PATTERN_LONG,
        PAT_COMPLIANT_RANDOM_PATTERN_SHORT, PAT_PRBS7, PAT_PRBS23, PAT_PRBS31
    } fast_pattern_t;
    // slow lane prbs choices
    typedef enum logic [1:0] {
        SLOW_PRBS31, SLOW_RESERVED, SLOW_PRBS7, SLOW_PRBS23
    } slow_prbs_t;
    // lane clock source choices
    typedef enum logic [1:0] {
        SRC_LANE0, SRC_LANE2, SRC_OWN
    } clock_source_t;
endpackage

// ==== verification/mgmt_host.sv ====
// management host issuing one-cycle register strobes
// assumes a free running management clock from the bench
`timescale 1ns/100ps
module mgmt_host (
    // clock and read answer
    input wire logic clock,
    input wire logic [15:0] regReadData,
    input wire logic regReadValid,
    // register port toward the device
    output logic regWrite,
    output logic regRead,
    output logic [4:0] regAddr,
    output logic [15:0] regWriteData
);
    initial {regWrite, regRead, regAddr, regWriteData} = '0;
    // one access over one taking edge; idle bus shows inverted values, not stale ones
    task acc(input logic w, input logic [4:0] a, input logic [15:0] v, output logic [15:0] d);
        @(posedge clock) #1;
        {regWrite, regRead, regAddr, regWriteData} = {w, !w, a, v};
        @(posedge clock) #1;
        {regWrite, regRead, regAddr, regWriteData} = {2'b00, ~a, ~v};
        d = regReadValid === 1'b1 ? regReadData : 16'hxxxx; // answer only counts with valid
    endtask
endmodule

// ==== verification/serdes_ctrl_monitor.sv ====
// assertions on the register port and the outputs it drives
// assumes binding into the register block, one clock, synchronous reset
`timescale 1ns/100ps
module serdes_ctrl_monitor (
    // clock, reset and register port
    input wire logic clock,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic [15:0] regReadData,
    // pattern engine and trigger pulses
    input wire logic fastSidePatternGenerate,
    input wire logic fastSidePatternVerify,
    input wire serdes_test_clock_reset_pkg::fast_pattern_t fastSidePatternChoice,
    input wire logic fastSidePatternError,
    input wire logic [3:0] slowLaneTxBufferClear,
    input wire logic [3:0] slowLaneRxBufferClear,
    input wire logic fastRxSecondBufferClear,
    input wire logic fastRxFirstBufferClear,
    input wire logic linkTrainingRerun,
    input wire logic datapathClear
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // write to the pattern and trigger registers, and two clean reads of the tally three cycles apart
    sequence patWr; regWrite && regAddr == 5'h0b; endsequence
    sequence trigWr; regWrite && regAddr == 5'h0e; endsequence
    sequence clearRead;
        regRead && regAddr == 5'h10 && !fastSidePatternError ##1 !fastSidePatternError [*2]
            ##1 regRead && regAddr == 5'h10;
    endsequence
    // fields follow the written word one cycle later, datapath and training pulses last one cycle
    pattern_enable_a: assert property (patWr |=> {fastSidePatternGenerate, fastSidePatternVerify} == $past(regWriteData[13:12]))
        else $error("pattern enables wrong");
    choice_follow_a: assert property (patWr |=> fastSidePatternChoice == $past(regWriteData[10:8])) else $error("choice wrong");
    tx_clear_a: assert property (regWrite && regAddr == 5'h0d |=> slowLaneTxBufferClear == $past(regWriteData[11:8]))
        else $error("tx clear wrong");
    rx_clear_a: assert property (trigWr |=> {slowLaneRxBufferClear, fastRxSecondBufferClear, fastRxFirstBufferClear}
        == $past({regWriteData[11:8], regWriteData[6:5]})) else $error("rx clear wrong");
    train_pulse_a: assert property (trigWr |=> linkTrainingRerun == $past(regWriteData[4])) else $error("training wrong");
    dp_pulse_a: assert property (trigWr |=> datapathClear == $past(regWriteData[3])) else $error("datapath wrong");
    pulse_drop_a: assert property (!(regWrite && regAddr == 5'h0e) |=> !datapathClear && !linkTrainingRerun)
        else $error("pulse stuck");
    tally_clear_a: assert property (clearRead |=> regReadData == 16'h0000) else $error("tally kept");
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the test, lane clock and reset trigger registers
// assumes the host model and monitor are compiled before it
`timescale 1ns/100ps
module tb_top;
    // design wiring, named as the ports so instances connect by name
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic fastSidePatternError = 1'b0;
    logic regWrite, regRead, regReadValid, fastSidePatternGenerate, fastSidePatternVerify, farEndDeepLoopback;
    logic fastRxSecondBufferClear, fastRxFirstBufferClear, linkTrainingRerun, datapathClear;
    logic [3:0] slowLaneTxBufferClear, slowLaneRxBufferClear;
    logic [4:0] regAddr, a;
    logic [15:0] regWriteData, regReadData, d, e;
    serdes_test_clock_reset_pkg::fast_pattern_t fastSidePatternChoice;
    serdes_test_clock_reset_pkg::slow_prbs_t slowLanePrbsChoice;
    serdes_test_clock_reset_pkg::clock_source_t laneThreeClockSource, laneTwoClockSource, laneOneClockSource;
    int failures = 0;
    int numChecks = 0;
    wire [7:0] patOut = {fastSidePatternGenerate, fastSidePatternVerify, fastSidePatternChoice, slowLanePrbsChoice, farEndDeepLoopback};
    wire [5:0] srcOut = {laneThreeClockSource, laneTwoClockSource, laneOneClockSource};
    wire [7:0] pulses = {slowLaneRxBufferClear, fastRxSecondBufferClear, fastRxFirstBufferClear, linkTrainingRerun, datapathClear};
    // address, written word, expected read back
    logic [36:0] rows [13] = '{{5'h0b, 16'hffff, 16'h3738}, {5'h0b, 16'h0000, 16'h0000}, {5'h0b, 16'h2118, 16'h2118},
        {5'h0b, 16'h1220, 16'h1220}, {5'h0b, 16'h0300, 16'h0300}, {5'h0b, 16'h0430, 16'h0430}, {5'h0b, 16'hc5c7, 16'h0500},
        {5'h0b, 16'h0610, 16'h0610}, {5'h0d, 16'h0f08, 16'h0008}, {5'h0d, 16'h00fe, 16'h000e}, {5'h0d, 16'h0005, 16'h0005},
        {5'h0e, 16'h0f78, 16'h0000}, {5'h12, 16'hffff, 16'h0000}};
    serdes_test_clock_reset_ctrl dut (.*);
    mgmt_host host (.*);
    initial forever #25 clock = ~clock;
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        if (failures == 0 && numChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // error pulses from the pattern checker, one idle cycle apart
    task fault(input int n);
        repeat (n) begin
            @(posedge clock) #1 fastSidePatternError = 1'b1;
            @(posedge clock) #1 fastSidePatternError = 1'b0;
        end
    endtask
    // hang guard, far beyond the roughly 135 cycles the run needs
    initial begin
        #100000;
        failures++;
        results();
    end
    // table first, then reset values, tally, triggers and single bit sweeps
    initial begin
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        foreach (rows[i]) begin
            a = rows[i][36:32];
            e = rows[i][15:0];
            host.acc(1'b1, a, rows[i][31:16], d);
            host.acc(1'b0, a, 16'h0000, d);
            chk(d, e, "read back");
            if (a == 5'h0b) chk(patOut, {e[13:12], e[10:8], e[5:3]}, "pattern");
            if (a == 5'h0d) chk(srcOut, {e[3] ? 2'h2 : {1'b0, e[2]}, e[1], 1'b0, e[0], 1'b0}, "sources");
        end
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        host.acc(1'b0, 5'h0b, 16'h0000, d);
        chk(d, 16'h0520, "pattern reset");
        chk(srcOut, 16'h0000, "source reset");
        host.acc(1'b1, 5'h0b, 16'h1000, d);
        fault(5);
        host.acc(1'b0, 5'h10, 16'h0000, d);
        chk(d, 16'hffff, "tally saturate");
        host.acc(1'b0, 5'h10, 16'h0000, d);
        chk(d, 16'h0000, "tally cleared");
        host.acc(1'b1, 5'h0b, 16'h2638, d);
        fault(2);
        host.acc(1'b0, 5'h10, 16'h0000, d);
        chk(d, 16'h0000, "tally idle");
        host.acc(1'b1, 5'h0e, 16'h0f78, d);
        chk(pulses, 16'h00ff, "triggers");
        host.acc(1'b1, 5'h0d, 16'h0a0b, d);
        chk(pulses, 16'h0000, "trigger drop");
        chk(slowLaneTxBufferClear, 16'h000a, "tx clear");
        host.acc(1'b0, 5'h0b, 16'h0000, d);
        chk(d, 16'h2638, "kept config");
        chk(slowLaneTxBufferClear, 16'h0000, "tx drop");
        for (int b = 3; b < 12; b++) begin
            host.acc(1'b1, 5'h0e, 16'h0001 << b, d);
            host.acc(1'b1, 5'h0d, 16'h0001 << b, d);
        end
        results();
    end
endmodule
bind serdes_test_clock_reset_ctrl serdes_ctrl_monitor mon (.*);
